// ### rtl/bus_frame_host_relay.sv
// relay of received bus frames, transmit echoes and polling data to the host
//
// Contract
// - valid control byte forwarded as standard/extended indication
// - data bytes after control passed unchanged
// - spi and 8-bit uart frames end with state
// - crc and marker appended per enabled features
// - receive error bit marks corrupted bytes
// - checksum/length bit marks bad sum or count
// - timing error bit marks standard timing violations
// - reserved frame-state bits always zero
// - marker mode doubles received 0xcb data bytes
// - marker mode doubles echoed 0xcb transmit bytes
// - consistent polling control byte forwarded to host
// - send poll state on address match, count above
// - slot setup accepted anytime, stored, reused
// - host master polling frame sent on bus
// - crc sixteen bit, polynomial 1021
// - crc seed ffff, no reflection, zero xor
// - crc check value 29b1 over 123456789
// - no marker: end shown by 2.6 ms silence
// - crc on: two crc bytes follow frame
// - feature enables set only, cleared by reset
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "relay_map.svh"

module bus_frame_host_relay #(
   parameter int unsigned silence_cycles = `SILENCE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // ahb-lite register slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // received bus bytes from the line receiver
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_last,
   input wire logic byte_corrupt_flag,
   input wire logic bit_timing_err_flag,
   output logic rx_ready,
   // bytes echoed by the line transmitter
   input wire logic echo_valid,
   input wire logic [7:0] echo_byte,
   output logic echo_ready,
   // byte stream toward the host link
   output logic host_out_valid,
   output logic [7:0] host_out_byte,
   input wire logic host_out_ready,
   output logic frame_end_marker_ind,
   output logic frame_result_ind,
   output relay_pkg::kind_type frame_kind,
   // slot answer toward the line transmitter
   output logic poll_tx_valid,
   output logic [3:0] poll_tx_slot,
   output logic [7:0] poll_tx_byte,
   // master polling frame from the host, out to the line transmitter
   input wire logic host_poll_valid,
   input wire logic [7:0] host_poll_byte,
   input wire logic host_poll_last,
   output logic host_poll_ready,
   output logic bus_tx_valid,
   output logic [7:0] bus_tx_byte,
   output logic bus_tx_last,
   input wire logic bus_tx_ready
);
   import relay_pkg::*;

   relay_state_type s; // registered state
   relay_state_type n; // next state
   crc_if crc_c ();    // link to the crc unit
   logic free;         // output byte register can take a byte
   logic rx_take;      // bus byte accepted this cycle
   logic ahb_take;     // address phase accepted this cycle
   logic [7:0] fs;     // frame-state byte being built

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // control byte classification; anything else is dropped
   function automatic logic ctrl_ok(input logic [7:0] b);
      return ((b & `CTRL_MASK) == `CTRL_STD) || ((b & `CTRL_MASK) == `CTRL_EXT) ||
             (b == `CTRL_POLL);
   endfunction

   // first tail state once the last bus byte is out
   function automatic state_type tail_start(input logic m, input logic c,
                                            input logic [1:0] mode);
      if (m) begin
         return ST_MARK;
      end else if (mode != LINK_UART9) begin
         return ST_FSTATE;
      end else if (c) begin
         return ST_CRC_HI;
      end
      return ST_SIL;
   endfunction

   // where a frame ends: marker mode needs no silence
   function automatic state_type tail_done(input logic m);
      return m ? ST_IDLE : ST_SIL;
   endfunction

   // register readback; address bits 9:8 are not decoded, other unmapped words read zero
   function automatic logic [31:0] reg_read(input relay_state_type r, input logic [31:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (a[31:`REG_UPPER_ZERO] == '0) begin
         case (a[7:0])
            `REG_CFG: begin
               v[`CFG_MARKER_BIT] = r.cfg_m;
               v[`CFG_CRC_BIT] = r.cfg_c;
               v[`CFG_AUTOPOLL_BIT] = r.cfg_p;
            end
            `REG_POLL: begin
               v[`POLL_STATE_LSB +: 8] = r.pstate;
               v[`POLL_ADDR_LSB +: 16] = r.paddr;
               v[`POLL_SLOT_LSB +: 4] = r.slot;
            end
            `REG_MODE: v[1:0] = r.mode;
            `REG_STATUS: begin
               v[`STAT_FSTATE_LSB +: 8] = r.last_fs;
               v[`STAT_KIND_LSB +: 2] = r.kind;
               v[`STAT_ARMED_BIT] = r.armed;
            end
            default: v = 32'h0000_0000;
         endcase
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // handshakes; all stall while the clock enable is low

   assign free = !s.out_v || host_out_ready;
   assign rx_ready = clk_en && ((s.st == ST_SKIP) ||
                     (free && !s.dup && (s.st == ST_IDLE || s.st == ST_DATA)));
   // echoes only between received frames, received bytes first
   assign echo_ready = clk_en && free && !s.dup && (s.st == ST_IDLE) && !rx_valid;
   assign host_poll_ready = clk_en && (!s.btx_v || bus_tx_ready);
   assign rx_take = rx_valid && rx_ready;
   assign ahb_take = hsel && htrans[1] && hready && clk_en;

   // crc runs over the original bus bytes of accepted frames only
   assign crc_c.init = rx_take && (s.st == ST_IDLE) && ctrl_ok(rx_byte);
   assign crc_c.step = rx_take && ((s.st == ST_DATA) ||
                       ((s.st == ST_IDLE) && ctrl_ok(rx_byte)));
   assign crc_c.data = rx_byte;

   crc16_unit u_crc (
      .clk(clk),
      .rst(rst),
      .clk_en(clk_en),
      .port_c(crc_c)
   );

   // frame-state byte: fixed base code, flags, reserved bits zero
   always_comb begin
      fs = `FSTATE_BASE;
      fs[`FS_RE_BIT] = s.re;
      fs[`FS_CE_BIT] = s.ce;
      fs[`FS_TE_BIT] = s.te;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      n = s;
      // single-cycle pulses drop by default
      n.ptx_v = 1'b0;
      n.fe_ind = 1'b0;
      n.fr_ind = 1'b0;
      n.ap_v = 1'b0;
      if (s.out_v && host_out_ready) begin
         n.out_v = 1'b0;
      end
      if (s.btx_v && bus_tx_ready) begin
         n.btx_v = 1'b0;
      end

      // ahb address phase: read data is sampled here, so it is ready in the data phase
      if (ahb_take) begin
         n.ap_v = 1'b1;
         n.ap_w = hwrite;
         n.ap_idx = (haddr[31:`REG_UPPER_ZERO] == '0) ? haddr[7:0] : 8'hff;
         n.rdata = reg_read(s, haddr);
      end

      // pending second copy of an escaped marker code goes first
      if (s.dup && free) begin
         n.out_v = 1'b1;
         n.out_b = `MARK_CODE;
         n.dup = 1'b0;
      end

      case (s.st)
         // wait for a control byte or a transmit echo
         ST_IDLE: begin
            if (rx_take) begin
               if (ctrl_ok(rx_byte)) begin
                  n.out_v = 1'b1;
                  n.out_b = rx_byte;
                  n.cnt = 9'h001;
                  n.chk = rx_byte;
                  n.re = byte_corrupt_flag;
                  n.te = bit_timing_err_flag;
                  n.ce = 1'b0;
                  if (rx_byte == `CTRL_POLL) begin
                     n.kind = KIND_POLL;
                     n.exp_len = `POLL_LEN;
                  end else begin
                     n.kind = ((rx_byte & `CTRL_MASK) == `CTRL_STD) ? KIND_STD : KIND_EXT;
                     n.exp_len = 9'h000;
                  end
                  if (rx_last) begin
                     // a lone control byte is always short
                     n.ce = 1'b1;
                     n.st = tail_start(s.cfg_m, s.cfg_c, s.mode);
                  end else begin
                     n.st = ST_DATA;
                  end
               end else if (!rx_last) begin
                  // inconsistent control byte: the frame is dropped
                  n.st = ST_SKIP;
               end
            end else if (echo_valid && echo_ready) begin
               n.out_v = 1'b1;
               n.out_b = echo_byte;
               n.dup = s.cfg_m && (echo_byte == `MARK_CODE);
            end
         end

         // data bytes pass unchanged; bookkeeping beside them
         ST_DATA: begin
            if (rx_take) begin
               n.out_v = 1'b1;
               n.out_b = rx_byte;
               n.dup = s.cfg_m && (rx_byte == `MARK_CODE);
               n.cnt = s.cnt + 9'h001;
               n.chk = s.chk ^ rx_byte;
               n.re = s.re | byte_corrupt_flag;
               n.te = s.te | bit_timing_err_flag;
               if (s.kind == KIND_STD && s.cnt == `STD_LEN_POS) begin
                  n.exp_len = `STD_OVERHEAD + {5'h00, rx_byte[3:0]};
               end
               if (s.kind == KIND_EXT && s.cnt == `EXT_LEN_POS) begin
                  n.exp_len = `EXT_OVERHEAD + {1'b0, rx_byte};
               end
               if (s.kind == KIND_POLL) begin
                  if (s.cnt == `POLL_ADDR_HI_POS) begin
                     n.rx_paddr[15:8] = rx_byte;
                  end
                  if (s.cnt == `POLL_ADDR_LO_POS) begin
                     n.rx_paddr[7:0] = rx_byte;
                  end
                  // answer only in a slot the master really offers
                  if (s.cnt == `POLL_SLOTCNT_POS && (s.armed || s.cfg_p) &&
                      s.rx_paddr == s.paddr && rx_byte[3:0] > s.slot) begin
                     n.ptx_v = 1'b1;
                     n.ptx_slot = s.slot;
                     n.ptx_b = s.pstate;
                     n.armed = 1'b0;
                  end
               end
               if (rx_last) begin
                  // sum of all bytes inverted-xor must be all ones
                  n.ce = ((s.chk ^ rx_byte) != `CHK_GOOD) ||
                         ((s.cnt + 9'h001) != s.exp_len);
                  n.st = tail_start(s.cfg_m, s.cfg_c, s.mode);
               end
            end
         end

         // swallow a rejected frame
         ST_SKIP: begin
            if (rx_take && rx_last) begin
               n.st = ST_IDLE;
            end
         end

         // frame-end marker, never escaped
         ST_MARK: begin
            if (free && !s.dup) begin
               n.out_v = 1'b1;
               n.out_b = `MARK_CODE;
               n.fe_ind = 1'b1;
               n.st = ST_FSTATE;
            end
         end

         // frame-state byte
         ST_FSTATE: begin
            if (free && !s.dup) begin
               n.out_v = 1'b1;
               n.out_b = fs;
               n.last_fs = fs;
               n.fr_ind = 1'b1;
               n.st = s.cfg_c ? ST_CRC_HI : tail_done(s.cfg_m);
            end
         end

         // crc, high byte first
         ST_CRC_HI: begin
            if (free && !s.dup) begin
               n.out_v = 1'b1;
               n.out_b = crc_c.value[15:8];
               n.st = ST_CRC_LO;
            end
         end

         ST_CRC_LO: begin
            if (free && !s.dup) begin
               n.out_v = 1'b1;
               n.out_b = crc_c.value[7:0];
               n.st = tail_done(s.cfg_m);
            end
         end

         // silence counted from the moment the last byte has left
         ST_SIL: begin
            if (s.out_v || s.dup) begin
               n.sil = 24'h000000;
            end else if (s.sil >= 24'(silence_cycles - 1)) begin
               n.sil = 24'h000000;
               n.st = ST_IDLE;
            end else begin
               n.sil = s.sil + 24'h000001;
            end
         end

         default: begin
            n.st = ST_IDLE;
         end
      endcase

      // master polling frame goes straight to the line transmitter
      if (host_poll_valid && host_poll_ready) begin
         n.btx_v = 1'b1;
         n.btx_b = host_poll_byte;
         n.btx_last = host_poll_last;
      end

      // ahb data phase: whole-word writes
      if (s.ap_v && s.ap_w) begin
         case (s.ap_idx)
            // features can only be switched on
            `REG_CFG: begin
               n.cfg_m = s.cfg_m | hwdata[`CFG_MARKER_BIT];
               n.cfg_c = s.cfg_c | hwdata[`CFG_CRC_BIT];
               n.cfg_p = s.cfg_p | hwdata[`CFG_AUTOPOLL_BIT];
            end
            // slot setup wins over a same-cycle use
            `REG_POLL: begin
               n.pstate = hwdata[`POLL_STATE_LSB +: 8];
               n.paddr = hwdata[`POLL_ADDR_LSB +: 16];
               n.slot = hwdata[`POLL_SLOT_LSB +: 4];
               n.armed = 1'b1;
            end
            `REG_MODE: n.mode = hwdata[1:0];
            default: n.mode = s.mode;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; reset clears the feature enables
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.st <= ST_IDLE;
         s.mode <= `MODE_RESET;
      end else if (clk_en) begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // zero-wait slave, always okay; held off while frozen
   assign hreadyout = clk_en;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;

   assign host_out_valid = s.out_v;
   assign host_out_byte = s.out_b;
   assign frame_end_marker_ind = s.fe_ind;
   assign frame_result_ind = s.fr_ind;
   assign frame_kind = s.kind;
   assign poll_tx_valid = s.ptx_v;
   assign poll_tx_slot = s.ptx_slot;
   assign poll_tx_byte = s.ptx_b;
   assign bus_tx_valid = s.btx_v;
   assign bus_tx_byte = s.btx_b;
   assign bus_tx_last = s.btx_last;

endmodule

`default_nettype wire

// ### common/relay_map.svh
// register offsets, field positions, codes and timing counts of the frame relay
`ifndef RELAY_MAP_SVH
`define RELAY_MAP_SVH

// register word offsets (byte addresses)
`define REG_CFG 8'h00
`define REG_POLL 8'h04
`define REG_MODE 8'h08
`define REG_STATUS 8'h0c
`define REG_UPPER_ZERO 10

// configuration register field positions
`define CFG_MARKER_BIT 0
`define CFG_CRC_BIT 1
`define CFG_AUTOPOLL_BIT 2

// poll setup register fields
`define POLL_STATE_LSB 0
`define POLL_ADDR_LSB 8
`define POLL_SLOT_LSB 24

// status register fields
`define STAT_FSTATE_LSB 0
`define STAT_KIND_LSB 8
`define STAT_ARMED_BIT 10

// frame-end marker code and frame-state byte layout
`define MARK_CODE 8'hcb
`define FSTATE_BASE 8'h03
`define FS_RE_BIT 7
`define FS_CE_BIT 6
`define FS_TE_BIT 5

// control byte classes
`define CTRL_MASK 8'hd3
`define CTRL_STD 8'h90
`define CTRL_EXT 8'h10
`define CTRL_POLL 8'hf0

// length field and frame size bookkeeping
`define STD_LEN_POS 9'h005
`define EXT_LEN_POS 9'h006
`define STD_OVERHEAD 9'h008
`define EXT_OVERHEAD 9'h009
`define POLL_LEN 9'h007
`define POLL_ADDR_HI_POS 9'h003
`define POLL_ADDR_LO_POS 9'h004
`define POLL_SLOTCNT_POS 9'h005
`define CHK_GOOD 8'hff

// crc parameters and reset values
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h1021
`define MODE_RESET 2'h0

// end-of-frame line silence, least time, rounded up to whole cycles
`define CLK_PERIOD_NS 8
`define SILENCE_NS 2600000
`define SILENCE_CYC ((`SILENCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### common/relay_pkg.sv
// types shared by the frame relay and its crc unit
package relay_pkg;

   // relay sequencing states
   typedef enum logic [3:0] {
      ST_IDLE, ST_DATA, ST_SKIP, ST_MARK, ST_FSTATE, ST_CRC_HI, ST_CRC_LO, ST_SIL
   } state_type;

   // class of the frame in flight
   typedef enum logic [1:0] {KIND_STD, KIND_EXT, KIND_POLL} kind_type;

   // host link flavour
   typedef enum logic [1:0] {LINK_SPI, LINK_UART8, LINK_UART9} link_type;

   // all state of the relay
   typedef struct packed {
      state_type st;
      kind_type kind;
      logic [8:0] cnt;
      logic [8:0] exp_len;
      logic [7:0] chk;
      logic re;
      logic te;
      logic ce;
      logic out_v;
      logic [7:0] out_b;
      logic dup;
      logic [23:0] sil;
      logic cfg_m;
      logic cfg_c;
      logic cfg_p;
      logic [1:0] mode;
      logic [3:0] slot;
      logic [15:0] paddr;
      logic [7:0] pstate;
      logic armed;
      logic [15:0] rx_paddr;
      logic ptx_v;
      logic [3:0] ptx_slot;
      logic [7:0] ptx_b;
      logic btx_v;
      logic [7:0] btx_b;
      logic btx_last;
      logic fe_ind;
      logic fr_ind;
      logic [7:0] last_fs;
      logic ap_v;
      logic ap_w;
      logic [7:0] ap_idx;
      logic [31:0] rdata;
   } relay_state_type;

   // state of the crc unit
   typedef struct packed {
      logic [15:0] crc;
   } crc_state_type;

endpackage

// ### common/crc_if.sv
// carrier between the relay and its crc unit
`timescale 1ns/10ps
`default_nettype none

interface crc_if;
   logic init;         // restart at the seed
   logic step;         // fold one byte in
   logic [7:0] data;   // byte to fold
   logic [15:0] value; // running crc

   modport user (output init, output step, output data, input value);
   modport unit (input init, input step, input data, output value);
endinterface

`default_nettype wire

// ### rtl/crc16_unit.sv
// byte-wide crc-16 with polynomial 1021, msb first
`timescale 1ns/10ps
`default_nettype none
`include "relay_map.svh"

module crc16_unit (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   crc_if.unit port_c
);
   import relay_pkg::*;

   crc_state_type s; // registered state
   crc_state_type n; // next state

   ////////////////////////////////////////////////////////////////////////////
   // one byte folded in, msb first, no reflection anywhere
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      logic fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[15] ^ d[i];
         r = {r[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next value: a step that coincides with init folds into the seed
   always_comb begin
      n = s;
      if (port_c.step) begin
         n.crc = crc_step(port_c.init ? `CRC_INIT : s.crc, port_c.data);
      end else if (port_c.init) begin
         n.crc = `CRC_INIT;
      end
   end

   // register; clock enable freezes it
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= crc_state_type'(`CRC_INIT);
      end else if (clk_en) begin
         s <= n;
      end
   end

   // final xor is zero, so the register is the result
   assign port_c.value = s.crc;

endmodule

`default_nettype wire

// ### verif/relay_chk.sv
// port-level assertions for the frame relay
`timescale 1ns/10ps
`default_nettype none

module relay_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic rx_ready,
   input wire logic echo_ready,
   input wire logic host_poll_ready,
   input wire logic host_out_valid,
   input wire logic [7:0] host_out_byte,
   input wire logic host_out_ready,
   input wire logic frame_end_marker_ind,
   input wire logic frame_result_ind,
   input wire logic poll_tx_valid,
   input wire logic bus_tx_valid,
   input wire logic [7:0] bus_tx_byte,
   input wire logic bus_tx_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
   a_ready_en: assert property (hreadyout == clk_en) else $error("hreadyout not clk_en");
   // a stalled host byte may not change under the host's feet
   a_out_hold: assert property (host_out_valid && !host_out_ready |=>
      host_out_valid && $stable(host_out_byte)) else $error("host byte dropped");
   a_tx_hold: assert property (bus_tx_valid && !bus_tx_ready |=>
      bus_tx_valid && $stable(bus_tx_byte)) else $error("bus byte dropped");
   a_marker_code: assert property (frame_end_marker_ind |->
      host_out_valid && host_out_byte == 8'hcb) else $error("marker code wrong");
   a_state_res: assert property (frame_result_ind |->
      host_out_valid && host_out_byte[4:0] == 5'h03) else $error("state byte bits");
   a_marker_first: assert property (frame_end_marker_ind |->
      ##[1:40] frame_result_ind) else $error("state byte missing after marker");
   a_poll_pulse: assert property (poll_tx_valid |=> !poll_tx_valid) else $error("slot pulse");
   // frozen clock enable must stall every handshake
   a_frozen_idle: assert property (!clk_en |-> !rx_ready && !echo_ready && !host_poll_ready)
      else $error("ready while frozen");
   c_marker: cover property (frame_end_marker_ind);
   c_state: cover property (frame_result_ind);
   c_stall: cover property (host_out_valid && !host_out_ready);
endmodule

bind bus_frame_host_relay relay_chk relay_chk_inst (.clk(clk), .rst(rst), .clk_en(clk_en),
   .hreadyout(hreadyout), .hresp(hresp), .rx_ready(rx_ready), .echo_ready(echo_ready),
   .host_poll_ready(host_poll_ready), .host_out_valid(host_out_valid),
   .host_out_byte(host_out_byte), .host_out_ready(host_out_ready),
   .frame_end_marker_ind(frame_end_marker_ind), .frame_result_ind(frame_result_ind),
   .poll_tx_valid(poll_tx_valid), .bus_tx_valid(bus_tx_valid), .bus_tx_byte(bus_tx_byte),
   .bus_tx_ready(bus_tx_ready));

`default_nettype wire

// ### verif/host_link_model.sv
// host side model: takes the relayed byte stream, stalling now and then
`timescale 1ns/10ps
`default_nettype none

module host_link_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic host_out_valid,
   input wire logic [7:0] host_out_byte,
   output logic host_out_ready
);
   logic [7:0] got[$]; // bytes taken, in order
   logic [1:0] ph_q; // stall phase
   // refuse one cycle in three so the relay must hold its byte
   assign host_out_ready = (ph_q != 2'h2);
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      ph_q <= rst ? 2'h0 : (ph_q == 2'h2 ? 2'h0 : ph_q + 2'h1);
      if (!rst && host_out_valid && host_out_ready) begin
         got.push_back(host_out_byte);
      end
   end
endmodule

`default_nettype wire

// ### verif/tb_bus_frame_host_relay.sv
// self-checking bench for the frame relay
`timescale 1ns/10ps
`default_nettype none

module tb_bus_frame_host_relay;
   import relay_pkg::*;
   typedef logic [7:0] bq_type[$];
   logic clk, rst, clk_en, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic rx_valid, rx_last, byte_corrupt_flag, bit_timing_err_flag, rx_ready;
   logic [7:0] rx_byte, echo_byte, host_out_byte, poll_tx_byte, host_poll_byte, bus_tx_byte;
   logic echo_valid, echo_ready, host_out_valid, host_out_ready;
   logic frame_end_marker_ind, frame_result_ind, poll_tx_valid;
   logic [3:0] poll_tx_slot;
   kind_type frame_kind;
   logic host_poll_valid, host_poll_last, host_poll_ready;
   logic bus_tx_valid, bus_tx_last, bus_tx_ready;
   int n_fail, num_checks, cyc;
   assign hready = hreadyout;
   ////////////////////////////////////////////////////////////////////////
   // every relay port has a bench signal of the same name
   bus_frame_host_relay #(.silence_cycles(20)) bus_frame_host_relay_inst (.*);
   host_link_model host_link_model_inst (.clk(clk), .rst(rst), .host_out_valid(host_out_valid),
      .host_out_byte(host_out_byte), .host_out_ready(host_out_ready));
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one ahb-lite single word transfer, master side
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
      do @(posedge clk); while (!hready);
      htrans <= 2'h0; hwdata <= wd;
      do @(posedge clk); while (!hready);
      rd = hrdata;
   endtask
   // msb-first crc, seeded with all ones, no final inversion
   function automatic logic [15:0] crc_of(input bq_type q);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {q[i], 8'h00};
         repeat (8) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
      end
      return c;
   endfunction
   // send one bus frame and compare what the host got
   task automatic frame(input bq_type fb, input logic e, input logic [7:0] fs,
                        input logic m, input logic c);
      bq_type ex;
      logic [15:0] crc;
      host_link_model_inst.got.delete();
      foreach (fb[i]) begin
         rx_valid <= 1'b1; rx_byte <= fb[i]; rx_last <= (i == fb.size() - 1);
         byte_corrupt_flag <= e; bit_timing_err_flag <= e;
         do @(posedge clk); while (!rx_ready);
         ex.push_back(fb[i]);
         if (m && fb[i] == 8'hcb) ex.push_back(8'hcb);
      end
      rx_valid <= 1'b0;
      if (m) ex.push_back(8'hcb);
      ex.push_back(fs);
      crc = crc_of(fb);
      if (c) begin
         ex.push_back(crc[15:8]);
         ex.push_back(crc[7:0]);
      end
      repeat (80) @(posedge clk);
      chk(host_link_model_inst.got.size(), ex.size());
      foreach (ex[i]) chk(host_link_model_inst.got[i], ex[i]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      rst = 1'b1; clk_en = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; rx_valid = 1'b0; rx_byte = 8'h00; rx_last = 1'b0;
      byte_corrupt_flag = 1'b0; bit_timing_err_flag = 1'b0; echo_valid = 1'b0;
      echo_byte = 8'h00; host_poll_valid = 1'b0; host_poll_byte = 8'h00;
      host_poll_last = 1'b0; bus_tx_ready = 1'b0; n_fail = 0; num_checks = 0; cyc = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      ahb(1'b0, 32'h0, 32'h0); chk(rd, 32'h0);
      ahb(1'b0, 32'h10, 32'h0); chk(rd, 32'h0);
      frame('{8'hb0, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'hcb, 8'hc0}, 1'b0, 8'h03, 0, 0);
      frame('{8'hb0, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'hcb, 8'hc1}, 1'b1, 8'he3, 0, 0);
      ahb(1'b0, 32'hc, 32'h0); chk(rd, 32'h0000_00e3);
      ahb(1'b1, 32'h0, 32'h3);
      ahb(1'b1, 32'h0, 32'h0);
      ahb(1'b0, 32'h0, 32'h0); chk(rd[2:0], 3'h3);
      ahb(1'b1, 32'h8, 32'h2);
      ahb(1'b0, 32'h8, 32'h0); chk(rd[1:0], 2'h2);
      frame('{8'hb0, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'hcb, 8'hc0}, 1'b0, 8'h03, 1, 1);
      ahb(1'b1, 32'h4, 32'h0312_3455);
      ahb(1'b0, 32'hc, 32'h0); chk(rd[10], 1'b1);
      frame('{8'hf0, 8'h11, 8'h22, 8'h12, 8'h34, 8'h05, 8'h1f}, 1'b0, 8'h03, 1, 1);
      ahb(1'b0, 32'hc, 32'h0); chk(rd[10:8], 3'h2);
      clk_en <= 1'b0;
      repeat (2) @(posedge clk);
      clk_en <= 1'b1;
      host_poll_valid <= 1'b1; host_poll_byte <= 8'hf0; host_poll_last <= 1'b1;
      do @(posedge clk); while (!host_poll_ready);
      host_poll_valid <= 1'b0;
      repeat (3) @(posedge clk);
      chk({bus_tx_valid, bus_tx_last, bus_tx_byte}, {2'h3, 8'hf0});
      bus_tx_ready <= 1'b1;
      repeat (3) @(posedge clk);
      print_verdict();
   end
endmodule

`default_nettype wire
